// >>> design/ms_tick_gen.sv
`timescale 1ns/10ps
module ms_tick_gen
   import wdt_pkg::*;
#(
   parameter int unsigned DIV = TICK_CYCLES
)
(
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   output logic      o_tick
);
   // A one-cycle divider would never drop the tick
   if (DIV < 2)
   begin : g_bad_div
      $error("DIV must be at least 2");
   end

   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt_r;

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_r  <= '0;
         o_tick <= 1'b0;
      end
      else if (cnt_r == W'(DIV - 1))
      begin
         cnt_r  <= '0;
         o_tick <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 1'b1;
         o_tick <= 1'b0;
      end
   end
endmodule // ms_tick_gen

// >>> design/supervisor_watchdog_reset.sv
// How it works
// R1: A manual reset low shorter than 1 ms never causes a reset.
// R2: A manual reset low held 20 ms or longer always causes a reset.
// R3: Timeout select picks 150 ms low, 600 ms open, 1.2 s high.
// R4: Threshold select picks the 5% trip level low, the 10% level high.
// R5: Active-high reset is high for undervoltage, expiry or manual reset.
// R6: Active-low reset pulls low for the same causes, open-drain.
// R7: Resets stay asserted one reset-active period after the cause ends.
// R8: After supply recovery the resets stay asserted 250 ms.
// R9: No falling kick edge within the timeout asserts both resets.
// R10: A falling kick edge or a low pulse of 75 ns restarts the count.
// R11: On watchdog expiry the resets stay asserted 250 ms.
// R12: Manual reset is active low, debounced, and forces reset while low.
// R13: The processor must kick the watchdog before each timeout.
// R14: The manual reset driver must hold it low at least 20 ms.
// R15: All ms timing comes from one prescaled tick.
// R16: Watchdog count is held clear during reset, restarts on release.
`timescale 1ns/10ps
module supervisor_watchdog_reset
   import wdt_pkg::*;
#(
   parameter int unsigned TICK_DIV    = TICK_CYCLES,
   parameter int unsigned DEBOUNCE_MS = 10
)
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_manual_reset_n_in,
   input  wire logic [1:0] i_timeout_select,
   input  wire logic       i_threshold_select,
   input  wire logic       i_uv_below_5pct,
   input  wire logic       i_uv_below_10pct,
   input  wire logic       i_watchdog_kick_n,
   output logic            o_reset,
   output logic            o_reset_n_out,
   output logic            o_reset_n_oe,
   output logic            o_threshold_10pct
);
   // Debounce must reject a 1 ms glitch yet qualify within 20 ms
   if (DEBOUNCE_MS <= GLITCH_MS || DEBOUNCE_MS >= QUALIFY_MS)
   begin : g_bad_debounce
      $error("DEBOUNCE_MS must lie strictly between 1 and 20");
   end

   // Counters are sized for these figures; a saturated kick count at
   // the match value would look like endless kicks
   if (TIMEOUT_HI_MS >= (1 << MS_W) || STRETCH_MS > 256 ||
       KICK_MIN_CYC > 14 || DEBOUNCE_MS > 31)
   begin : g_bad_width
      $error("Timing figures overflow the counter widths");
   end

   typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_STRETCH} sup_state_t;

   logic             tick;
   logic             kick_d_r;
   logic [3:0]       kick_low_r;
   logic             kick_restart;
   logic [MS_W-1:0]  wd_cnt_r;
   logic [MS_W-1:0]  wd_limit;
   logic             wd_expire;
   logic [4:0]       mr_cnt_r;
   logic             mr_qual_r;
   logic             uv_now;
   logic             cause;
   sup_state_t       state_r;
   logic [7:0]       stretch_r;

   // One prescaled tick drives every millisecond count
   ms_tick_gen #(.DIV(TICK_DIV)) u_ms_tick_gen ( // [R15]
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .o_tick     (tick)
   );

   // Undervoltage trip level chosen by strap
   assign uv_now = i_threshold_select ? i_uv_below_10pct
                                      : i_uv_below_5pct; // [R4]

   // Strap copy lets the board confirm which trip level is live
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         o_threshold_10pct <= 1'b0;
      else
         o_threshold_10pct <= i_threshold_select; // [R4]
   end

   // Code 3 cannot come from a three-level strap; treat it as open
   always_comb
   begin
      case (i_timeout_select) // [R3]
         TSEL_LOW:  wd_limit = MS_W'(TIMEOUT_LO_MS);
         TSEL_OPEN: wd_limit = MS_W'(TIMEOUT_MD_MS);
         TSEL_HIGH: wd_limit = MS_W'(TIMEOUT_HI_MS);
         default:   wd_limit = MS_W'(TIMEOUT_MD_MS);
      endcase
   end

   // Kick: falling edge, or a low lasting the minimum width
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         // Idle level, so release is no false edge
         kick_d_r   <= 1'b1;
         kick_low_r <= '0;
      end
      else
      begin
         kick_d_r <= i_watchdog_kick_n;
         if (i_watchdog_kick_n)
            kick_low_r <= '0;
         else if (kick_low_r != 4'hf)
            kick_low_r <= kick_low_r + 4'h1;
      end
   end

   // Held low counts once; a steady low must not look like repeated kicks
   assign kick_restart = (kick_d_r && !i_watchdog_kick_n)
      || (kick_low_r == 4'(KICK_MIN_CYC)); // [R10]

   // Held clear outside RUN so every release starts a full period
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         wd_cnt_r <= '0;
      else if (state_r != ST_RUN || kick_restart)
         wd_cnt_r <= '0; // [R16] [R10]
      else if (tick && !wd_expire)
         wd_cnt_r <= wd_cnt_r + 1'b1;
   end

   assign wd_expire = (state_r == ST_RUN) && (wd_cnt_r >= wd_limit); // [R9]

   // Debounce: low must persist DEBOUNCE_MS ticks; any high restarts
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mr_cnt_r  <= '0;
         mr_qual_r <= 1'b0;
      end
      else if (i_manual_reset_n_in)
      begin
         mr_cnt_r  <= '0; // [R1]
         mr_qual_r <= 1'b0;
      end
      else if (tick)
      begin
         if (mr_cnt_r >= 5'(DEBOUNCE_MS - 1))
            mr_qual_r <= 1'b1; // [R2] [R12]
         else
            mr_cnt_r <= mr_cnt_r + 5'h01;
      end
   end

   assign cause = uv_now || mr_qual_r; // [R5]

   // Tick quantised: each hold may end up to one tick short
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r   <= ST_HOLD;
         stretch_r <= '0;
      end
      else
      begin
         case (state_r)
            ST_RUN:
            begin
               stretch_r <= '0;
               if (cause)
                  state_r <= ST_HOLD;
               else if (wd_expire)
                  state_r <= ST_STRETCH; // [R9] [R11]
            end
            ST_HOLD:
            begin
               stretch_r <= '0;
               // Stretch starts only once every cause is gone
               if (!cause)
                  state_r <= ST_STRETCH; // [R7]
            end
            ST_STRETCH:
            begin
               // A fresh cause restarts the whole hold
               if (cause)
               begin
                  state_r   <= ST_HOLD;
                  stretch_r <= '0;
               end
               else if (tick)
               begin
                  if (stretch_r >= 8'(STRETCH_MS - 1))
                     state_r <= ST_RUN; // [R8] [R11] [R16]
                  else
                     stretch_r <= stretch_r + 8'h01;
               end
            end
            default:
               state_r <= ST_HOLD;
         endcase
      end
   end

   // Registered outputs; open-drain pin only ever drives low
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_reset       <= 1'b1;
         o_reset_n_out <= 1'b0;
         o_reset_n_oe  <= 1'b1;
      end
      else
      begin
         o_reset       <= (state_r != ST_RUN); // [R5]
         o_reset_n_out <= 1'b0;
         o_reset_n_oe  <= (state_r != ST_RUN); // [R6]
      end
   end
endmodule // supervisor_watchdog_reset

// >>> design/wdt_pkg.sv
package wdt_pkg;
   // Core clock and timebase
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned TICK_US       = 1000;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
   // Millisecond figures
   localparam int unsigned GLITCH_MS     = 1;
   localparam int unsigned QUALIFY_MS    = 20;
   localparam int unsigned TIMEOUT_LO_MS = 150;
   localparam int unsigned TIMEOUT_MD_MS = 600;
   localparam int unsigned TIMEOUT_HI_MS = 1200;
   localparam int unsigned STRETCH_MS    = 250;
   // Kick low pulse minimum
   localparam int unsigned KICK_MIN_NS   = 75;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned KICK_MIN_CYC  =
      (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Timeout select encoding (three-level strap)
   localparam logic [1:0] TSEL_LOW  = 2'h0;
   localparam logic [1:0] TSEL_OPEN = 2'h1;
   localparam logic [1:0] TSEL_HIGH = 2'h2;
   localparam int unsigned MS_W     = 11;
endpackage

// >>> testbench/proc_kicker.sv
`timescale 1ns/10ps
module proc_kicker
(
   input  wire logic        i_core_clk,
   input  wire logic        i_en,
   input  wire logic [15:0] i_gap,
   output logic             o_kick_n
);
   logic [15:0] cnt_r;
   always_ff @(posedge i_core_clk)
      cnt_r <= (!i_en || cnt_r >= i_gap) ? 16'h0000 : cnt_r + 16'h0001;
   // Two low cycles per gap give a clean falling edge each time
   always_ff @(posedge i_core_clk)
      o_kick_n <= !(i_en && cnt_r < 16'h0002);
endmodule // proc_kicker

// >>> testbench/supervisor_watchdog_reset_tb.sv
`timescale 1ns/10ps
module supervisor_watchdog_reset_tb;
   import wdt_pkg::*;
   localparam int unsigned TD = 4;
   logic clk = 1'b0, rst = 1'b1, man_n = 1'b1, thr = 1'b0, k_en = 1'b0;
   logic uv5 = 1'b0, uv10 = 1'b0, kick_n, rst_o, rst_n, rst_oe, thr_o;
   logic [1:0] tsel = 2'h0;
   int errors = 0, n_tests = 0, cycles = 0;
   always #4 clk = ~clk;
   supervisor_watchdog_reset #(.TICK_DIV(TD), .DEBOUNCE_MS(2))
      u_supervisor_watchdog_reset (.i_core_clk(clk), .i_rst(rst),
      .i_manual_reset_n_in(man_n), .i_timeout_select(tsel),
      .i_threshold_select(thr), .i_uv_below_5pct(uv5), .i_uv_below_10pct(uv10),
      .i_watchdog_kick_n(kick_n), .o_reset(rst_o), .o_reset_n_out(rst_n),
      .o_reset_n_oe(rst_oe), .o_threshold_10pct(thr_o));
   proc_kicker u_proc_kicker (.i_core_clk(clk), .i_en(k_en),
      .i_gap(16'h0064), .o_kick_n(kick_n));
   task automatic close_out;
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk_rst(input logic exp, input string m);
      n_tests++;
      if (rst_o !== exp || rst_oe !== exp || rst_n !== 1'b0)
      begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic chk_thr(input logic exp, input string m);
      n_tests++;
      if (thr_o !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic t_uv;
      for (int t = 0; t < 2; t++)
      begin
         thr = t[0];
         {uv5, uv10} = t ? 2'h2 : 2'h1;
         cyc(20);
         chk_rst(1'b0, "wrong trip");
         chk_thr(t[0], "threshold copy");
         {uv5, uv10} = t ? 2'h1 : 2'h2;
         cyc(3);
         chk_rst(1'b1, "uv ignored");
         {uv5, uv10} = 2'h0;
         cyc(STRETCH_MS * TD - 8);
         chk_rst(1'b1, "early release");
         cyc(20);
         chk_rst(1'b0, "no release");
      end
   endtask
   task automatic t_man;
      man_n = 1'b0;
      cyc(TD - 1);
      man_n = 1'b1;
      cyc(40);
      chk_rst(1'b0, "glitch taken");
      man_n = 1'b0;
      cyc(QUALIFY_MS * TD);
      chk_rst(1'b1, "manual ignored");
      man_n = 1'b1;
      cyc(STRETCH_MS * TD - 8);
      chk_rst(1'b1, "early release");
      cyc(20);
      chk_rst(1'b0, "no release");
   endtask
   task automatic t_wdt;
      int lim, n;
      for (int s = 0; s < 4; s++)
      begin
         lim = s == 0 ? TIMEOUT_LO_MS : s == 2 ? TIMEOUT_HI_MS : TIMEOUT_MD_MS;
         tsel = s[1:0];
         cyc(2 * lim * TD);
         chk_rst(1'b0, "kicked yet reset");
         k_en = 1'b0;
         cyc(lim * TD - 110);
         chk_rst(1'b0, "early expiry");
         n = 0;
         while (rst_o !== 1'b1 && n < 200)
         begin
            cyc(1);
            n++;
         end
         chk_rst(1'b1, "no expiry");
         cyc(STRETCH_MS * TD - 8);
         chk_rst(1'b1, "short hold");
         k_en = 1'b1;
         cyc(20);
         chk_rst(1'b0, "no release");
      end
   endtask
   initial
   begin
      cyc(8);
      rst = 1'b0;
      k_en = 1'b1;
      cyc(STRETCH_MS * TD + 20);
      chk_rst(1'b0, "stuck after reset");
      t_uv;
      t_man;
      t_wdt;
      close_out;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 60000)
      begin
         errors++;
         close_out;
      end
   end
endmodule // supervisor_watchdog_reset_tb
bind supervisor_watchdog_reset wdt_properties #(.TICK_DIV(TICK_DIV),
   .DEBOUNCE_MS(DEBOUNCE_MS)) u_wdt_properties (
   .i_core_clk          (i_core_clk),
   .i_rst               (i_rst),
   .i_manual_reset_n_in (i_manual_reset_n_in),
   .i_timeout_select    (i_timeout_select),
   .i_threshold_select  (i_threshold_select),
   .i_uv_below_5pct     (i_uv_below_5pct),
   .i_uv_below_10pct    (i_uv_below_10pct),
   .i_watchdog_kick_n   (i_watchdog_kick_n),
   .o_reset             (o_reset),
   .o_reset_n_out       (o_reset_n_out),
   .o_reset_n_oe        (o_reset_n_oe),
   .o_threshold_10pct   (o_threshold_10pct));

// >>> testbench/wdt_properties.sv
`timescale 1ns/10ps
module wdt_properties
   import wdt_pkg::*;
#(
   parameter int unsigned TICK_DIV    = 4,
   parameter int unsigned DEBOUNCE_MS = 2
)
(
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic       i_manual_reset_n_in,
   input wire logic [1:0] i_timeout_select,
   input wire logic       i_threshold_select,
   input wire logic       i_uv_below_5pct,
   input wire logic       i_uv_below_10pct,
   input wire logic       i_watchdog_kick_n,
   input wire logic       o_reset,
   input wire logic       o_reset_n_out,
   input wire logic       o_reset_n_oe,
   input wire logic       o_threshold_10pct
);
   int unsigned low_c, idle_c, run_c, lim;
   // One tick of slack below the timeout, two above, timing is tick quantised
   assign lim = (i_timeout_select == 2'h0) ? TIMEOUT_LO_MS :
      (i_timeout_select == 2'h2) ? TIMEOUT_HI_MS : TIMEOUT_MD_MS;
   always_ff @(posedge i_core_clk or posedge i_rst)
      if (i_rst)
      begin
         low_c  <= 0;
         idle_c <= 0;
         run_c  <= 0;
      end
      else
      begin
         low_c  <= i_manual_reset_n_in ? 0 : low_c + 1;
         idle_c <= (o_reset || $fell(i_watchdog_kick_n)) ? 0 : idle_c + 1;
         run_c  <= o_reset ? run_c + 1 : 0;
      end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   chk_oe_mirror: assert property (o_reset_n_oe == o_reset)
      else $error("oe differs");
   chk_drain_low: assert property (o_reset_n_out == 1'b0)
      else $error("pin data high");
   chk_uv_low: assert property (!i_threshold_select &&
      i_uv_below_5pct |-> ##2 o_reset) else $error("uv5 missed");
   chk_uv_high: assert property (i_threshold_select &&
      i_uv_below_10pct |-> ##2 o_reset) else $error("uv10 missed");
   chk_stretch_min: assert property ($fell(o_reset) |->
      run_c >= (STRETCH_MS - 1) * TICK_DIV) else $error("short hold");
   chk_wdt_bound: assert property (!o_reset |->
      idle_c < (lim + 2) * TICK_DIV) else $error("late expiry");
   chk_wdt_early: assert property ($rose(o_reset) &&
      i_manual_reset_n_in && !i_uv_below_5pct && !i_uv_below_10pct
      |-> idle_c >= (lim - 1) * TICK_DIV) else $error("early expiry");
   chk_manual_qual: assert property (
      low_c == (DEBOUNCE_MS + 2) * TICK_DIV |-> ##[0:4] o_reset)
      else $error("manual missed");
   cover property ($rose(o_reset) && !i_manual_reset_n_in);
   cover property ($rose(o_reset) && i_threshold_select);
   cover property ($rose(o_reset) && i_timeout_select == 2'h2);
endmodule // wdt_properties
